// ### hdl/irq_group2_request_enable.sv
// Purpose: group-two interrupt request latching, enables and edge select
// Assumes: single clock mclk, synchronous srst, plain register port
// Notes: read data valid the cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
module irq_group2_request_enable (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // register port
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // request sources
  input wire logic timerThreeRequest,
  input wire logic serialRxRequest,
  input wire logic serialTxRequest,
  input wire logic transferRequest,
  input wire logic [irq_group2_pkg::PORT_PINS-1:0] portCPins,
  // core side
  output logic coreRequest,
  output irq_group2_pkg::level_t coreLevel,
  output logic [7:0] coreSources,
  // event interrupt
  output logic irqOut
);
  import irq_group2_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] group2_pending_requests;
  logic [7:0] group2_enable_upper_bits;
  logic [7:0] group2_enable_lower_bits;
  logic [PORT_PINS-1:0] pin_edge_select;
  logic globalEnable;
  logic [1:0] eventStatus;
  logic [1:0] eventEnable;

  ////////////////////////////////////////////////////////////////////////////
  // functions
  function automatic level_t levelOf(input logic upper, input logic lower);
    levelOf = level_t'({upper, lower});
  endfunction

  function automatic logic [1:0] levelRank(input level_t lvl);
    levelRank = lvl;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request sources
  logic [PORT_PINS-1:0] pinEdge;

  pin_edge_detect edgeUnit (
    .mclk(mclk),
    .srst(srst),
    .pinLevel(portCPins),
    .edgeSelect(pin_edge_select),
    .pinEdge(pinEdge)
  );

  wire [7:0] sourceRequest = {timerThreeRequest, serialRxRequest, serialTxRequest,
                              transferRequest, pinEdge};

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire hitPending = (regAddr == ADDR_PENDING);
  wire hitUpper = (regAddr == ADDR_ENABLE_UPPER);
  wire hitLower = (regAddr == ADDR_ENABLE_LOWER);
  wire hitEdge = (regAddr == ADDR_EDGE_SELECT);
  wire hitEvStatus = (regAddr == ADDR_EVENT_STATUS);
  wire hitEvEnable = (regAddr == ADDR_EVENT_ENABLE);
  wire hitEvClear = (regAddr == ADDR_EVENT_CLEAR);
  wire hitGlobal = (regAddr == ADDR_GLOBAL_CTRL);
  wire writePending = regWrite && hitPending;
  wire clearEvents = regWrite && hitEvClear;

  logic [7:0] readMux;
  always_comb begin
    if (hitPending) begin
      readMux = group2_pending_requests;
    end else if (hitUpper) begin
      readMux = group2_enable_upper_bits;
    end else if (hitLower) begin
      readMux = group2_enable_lower_bits;
    end else if (hitEdge) begin
      readMux = {4'h0, pin_edge_select};
    end else if (hitEvStatus) begin
      readMux = {6'h00, eventStatus};
    end else if (hitEvEnable) begin
      readMux = {6'h00, eventEnable};
    end else if (hitGlobal) begin
      readMux = {7'h00, globalEnable};
    end else begin
      readMux = RESET_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending latch: a new request wins over a software write of zero
  wire [7:0] next_pending = (writePending ? regWdata : group2_pending_requests)
                            | sourceRequest;

  always_ff @(posedge mclk) begin
    if (srst) begin
      group2_pending_requests <= RESET_BYTE;
    end else begin
      group2_pending_requests <= next_pending;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      group2_enable_upper_bits <= RESET_BYTE;
      group2_enable_lower_bits <= RESET_BYTE;
      pin_edge_select <= {PORT_PINS{1'b0}};
      globalEnable <= 1'b0;
      eventEnable <= RESET_EVENTS;
    end else if (regWrite) begin
      if (hitUpper) begin
        group2_enable_upper_bits <= regWdata;
      end
      if (hitLower) begin
        group2_enable_lower_bits <= regWdata;
      end
      if (hitEdge) begin
        pin_edge_select <= regWdata[PORT_PINS-1:0];
      end
      if (hitGlobal) begin
        globalEnable <= regWdata[0];
      end
      if (hitEvEnable) begin
        eventEnable <= regWdata[1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      regRdata <= RESET_BYTE;
    end else begin
      regRdata <= regRead ? readMux : RESET_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority selection toward the core
  wire [7:0] enabledPending = group2_pending_requests
                              & (group2_enable_upper_bits | group2_enable_lower_bits);

  level_t bestLevel;
  always_comb begin
    bestLevel = LEVEL_OFF;
    for (int i = 0; i < 8; i++) begin
      if (enabledPending[i] &&
          levelRank(levelOf(group2_enable_upper_bits[i], group2_enable_lower_bits[i]))
          > levelRank(bestLevel)) begin
        bestLevel = levelOf(group2_enable_upper_bits[i], group2_enable_lower_bits[i]);
      end
    end
  end

  wire forwardNow = globalEnable && (enabledPending != 8'h00);

  always_ff @(posedge mclk) begin
    if (srst) begin
      coreRequest <= 1'b0;
      coreLevel <= LEVEL_OFF;
      coreSources <= RESET_BYTE;
    end else begin
      coreRequest <= forwardNow;
      coreLevel <= forwardNow ? bestLevel : LEVEL_OFF;
      coreSources <= forwardNow ? enabledPending : RESET_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event status: request latched, and request arriving on a set bit
  wire [1:0] eventSet;
  assign eventSet[EVT_REQUEST] = (sourceRequest != 8'h00);
  assign eventSet[EVT_OVERRUN] = ((sourceRequest & group2_pending_requests) != 8'h00);

  always_ff @(posedge mclk) begin
    if (srst) begin
      eventStatus <= RESET_EVENTS;
    end else begin
      eventStatus <= (eventStatus & ~(clearEvents ? regWdata[1:0] : 2'h0)) | eventSet;
    end
  end

  assign irqOut = (eventStatus & eventEnable) != 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_SET_PENDING: assert property (@(posedge mclk) disable iff (srst)
    timerThreeRequest |=> group2_pending_requests[BIT_TIMER_THREE])
    else $error("timer request not latched");
  AST_PIN_PENDING: assert property (@(posedge mclk) disable iff (srst)
    (pinEdge != 4'h0) |=> ((group2_pending_requests[3:0] & $past(pinEdge)) == $past(pinEdge)))
    else $error("pin request not latched");
  AST_FORWARD: assert property (@(posedge mclk) disable iff (srst)
    (globalEnable && enabledPending != 8'h00) |=> coreRequest)
    else $error("enabled pending request not forwarded");
  AST_NO_FORWARD: assert property (@(posedge mclk) disable iff (srst)
    !globalEnable |=> !coreRequest && coreLevel == LEVEL_OFF)
    else $error("request forwarded while globally disabled");
  AST_READ_PENDING: assert property (@(posedge mclk) disable iff (srst)
    (regRead && hitPending && !$past(srst)) |=> regRdata == $past(group2_pending_requests))
    else $error("pending read wrong");
  AST_WRITE_UPPER: assert property (@(posedge mclk) disable iff (srst)
    (regWrite && hitUpper) ##1 (regRead && hitUpper && !regWrite)
    |=> regRdata == $past(regWdata, 2))
    else $error("enable upper readback wrong");
  AST_WRITE_LOWER: assert property (@(posedge mclk) disable iff (srst)
    (regWrite && hitLower) |=> group2_enable_lower_bits == $past(regWdata))
    else $error("enable lower not written");
  AST_RESET_ZERO: assert property (@(posedge mclk)
    srst |=> group2_pending_requests == 8'h00 && group2_enable_upper_bits == 8'h00)
    else $error("reset values wrong");
  AST_EDGE: assert property (@(posedge mclk) disable iff (srst)
    (pinEdge[0] == ((portCPins[0] && !$past(portCPins[0]) && !pin_edge_select[0]) ||
    (!portCPins[0] && $past(portCPins[0]) && pin_edge_select[0]))))
    else $error("pin edge wrong");
  AST_DISABLED: assert property (@(posedge mclk) disable iff (srst)
    (group2_enable_upper_bits == 8'h00 && group2_enable_lower_bits == 8'h00)
    |=> !coreRequest)
    else $error("disabled sources forwarded");
endmodule
`default_nettype wire

// ### hdl/pin_edge_detect.sv
// Purpose: per-pin edge detection for port C request pins
// Assumes: pins synchronous to mclk
// Notes: edge select 0 = rising, 1 = falling
`timescale 1ns/1ns
`default_nettype none
module pin_edge_detect (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // pins
  input wire logic [irq_group2_pkg::PORT_PINS-1:0] pinLevel,
  input wire logic [irq_group2_pkg::PORT_PINS-1:0] edgeSelect,
  // request pulses
  output logic [irq_group2_pkg::PORT_PINS-1:0] pinEdge
);
  import irq_group2_pkg::*;
  logic [PORT_PINS-1:0] lastLevel;
  wire [PORT_PINS-1:0] riseSeen = pinLevel & ~lastLevel;
  wire [PORT_PINS-1:0] fallSeen = ~pinLevel & lastLevel;
  assign pinEdge = (riseSeen & ~edgeSelect) | (fallSeen & edgeSelect);
  always_ff @(posedge mclk) begin
    if (srst) begin
      lastLevel <= {PORT_PINS{1'b0}};
    end else begin
      lastLevel <= pinLevel;
    end
  end
endmodule
`default_nettype wire

// ### inc/irq_group2_pkg.sv
// Purpose: constants for the group-two interrupt request block
// Assumes: 12-bit register address, 8-bit data
// Notes: event status, enable and clear words sit beside the documented map
package irq_group2_pkg;
  localparam logic [11:0] ADDR_PENDING = 12'hFC6;
  localparam logic [11:0] ADDR_ENABLE_UPPER = 12'hFC7;
  localparam logic [11:0] ADDR_ENABLE_LOWER = 12'hFC8;
  localparam logic [11:0] ADDR_EDGE_SELECT = 12'hFC9;
  localparam logic [11:0] ADDR_EVENT_STATUS = 12'hFCA;
  localparam logic [11:0] ADDR_EVENT_ENABLE = 12'hFCB;
  localparam logic [11:0] ADDR_EVENT_CLEAR = 12'hFCC;
  localparam logic [11:0] ADDR_GLOBAL_CTRL = 12'hFCD;
  localparam int BIT_TIMER_THREE = 7;
  localparam int BIT_SERIAL_RX = 6;
  localparam int BIT_SERIAL_TX = 5;
  localparam int BIT_TRANSFER = 4;
  localparam int PORT_PINS = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_EVENTS = 2'h0;
  localparam int EVT_REQUEST = 0;
  localparam int EVT_OVERRUN = 1;
  typedef enum logic [1:0] {
    LEVEL_OFF = 2'b00,
    LEVEL_LOW = 2'b01,
    LEVEL_NOMINAL = 2'b10,
    LEVEL_HIGH = 2'b11
  } level_t;
endpackage

// ### tb/irq_group2_request_enable_test.sv
// Purpose: self-checking bench for the group-two request block
// Assumes: 50 MHz mclk, synchronous srst held 8 cycles
// Notes: read results are checked from a queue by a separate monitor
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module irq_group2_request_enable_test;
  import irq_group2_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic timerThreeRequest, serialRxRequest, serialTxRequest, transferRequest;
  logic [3:0] portCPins;
  logic [3:0] fire = 4'h0;
  logic [3:0] pinDrive = 4'h0;
  logic coreRequest, irqOut;
  level_t coreLevel;
  logic [7:0] coreSources;
  logic [7:0] expQ[$];
  logic readSeen = 1'b0;
  logic [7:0] v;
  logic [7:0] expNow;
  int bad_count = 0;
  int tests_run = 0;
  always #10 mclk = ~mclk;
  request_sources src (.mclk(mclk), .fire(fire), .pinDrive(pinDrive),
    .timerThreeRequest(timerThreeRequest), .serialRxRequest(serialRxRequest),
    .serialTxRequest(serialTxRequest), .transferRequest(transferRequest),
    .portCPins(portCPins));
  irq_group2_request_enable dut (.mclk(mclk), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .timerThreeRequest(timerThreeRequest), .serialRxRequest(serialRxRequest),
    .serialTxRequest(serialTxRequest), .transferRequest(transferRequest),
    .portCPins(portCPins), .coreRequest(coreRequest), .coreLevel(coreLevel),
    .coreSources(coreSources), .irqOut(irqOut));
  ////////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (readSeen) begin
      expNow = expQ.pop_front();
      `CHK(regRdata, expNow)
    end
    readSeen <= regRead;
  end
  ////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge mclk);
    regRead <= 1'b0;
  endtask
  task wrRd(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    expQ.push_back(d);
    @(posedge mclk);
    regRead <= 1'b0;
  endtask
  task pulse(input logic [3:0] m);
    @(posedge mclk);
    fire <= m;
    @(posedge mclk);
    fire <= 4'h0;
  endtask
  task pins(input logic [3:0] p);
    @(posedge mclk);
    pinDrive <= p;
    repeat (3) @(posedge mclk);
  endtask
  task nap;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  task waitCore;
    int i;
    for (i = 0; i < 8 && coreRequest !== 1'b1; i++) @(negedge mclk);
    if (coreRequest !== 1'b1) begin
      bad_count++;
      end_of_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(1));
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    rd(ADDR_PENDING, 8'h00);
    rd(ADDR_ENABLE_UPPER, 8'h00);
    rd(ADDR_ENABLE_LOWER, 8'h00);
    rd(12'hFCF, 8'h00);
    for (int k = 0; k < 2; k++) begin
      v = 8'($urandom);
      wr(ADDR_ENABLE_LOWER, ~v);
      wrRd(ADDR_ENABLE_UPPER, v);
      rd(ADDR_ENABLE_LOWER, ~v);
    end
    wr(ADDR_ENABLE_UPPER, 8'h00);
    wr(ADDR_ENABLE_LOWER, 8'h00);
    wr(ADDR_PENDING, 8'h5A);
    rd(ADDR_PENDING, 8'h5A);
    wr(ADDR_PENDING, 8'h00);
    for (int b = 0; b < 4; b++) begin
      pulse(4'(1 << b));
      rd(ADDR_PENDING, 8'h10 << b);
      wr(ADDR_PENDING, 8'h00);
      rd(ADDR_PENDING, 8'h00);
    end
    wr(ADDR_EDGE_SELECT, 8'h00);
    pins(4'hF);
    rd(ADDR_PENDING, 8'h0F);
    wr(ADDR_PENDING, 8'h00);
    wr(ADDR_EDGE_SELECT, 8'h0F);
    pins(4'h0);
    rd(ADDR_PENDING, 8'h0F);
    wr(ADDR_PENDING, 8'h00);
    pins(4'hF);
    rd(ADDR_PENDING, 8'h00);
    wr(ADDR_ENABLE_UPPER, 8'h80);
    wr(ADDR_GLOBAL_CTRL, 8'h00);
    pulse(4'h8);
    nap();
    `CHK(coreRequest, 1'b0)
    rd(ADDR_PENDING, 8'h80);
    wr(ADDR_GLOBAL_CTRL, 8'h01);
    waitCore();
    `CHK(coreSources, 8'h80)
    `CHK(coreLevel, LEVEL_NOMINAL)
    wr(ADDR_ENABLE_UPPER, 8'h00);
    nap();
    `CHK(coreRequest, 1'b0)
    wr(ADDR_ENABLE_LOWER, 8'h80);
    waitCore();
    `CHK(coreLevel, LEVEL_LOW)
    wr(ADDR_EVENT_CLEAR, 8'h03);
    wr(ADDR_EVENT_ENABLE, 8'h01);
    nap();
    `CHK(irqOut, 1'b0)
    pulse(4'h1);
    nap();
    `CHK(irqOut, 1'b1)
    rd(ADDR_EVENT_STATUS, 8'h01);
    wr(ADDR_EVENT_ENABLE, 8'h00);
    nap();
    `CHK(irqOut, 1'b0)
    wr(ADDR_EVENT_CLEAR, 8'h01);
    wr(ADDR_EVENT_ENABLE, 8'h01);
    nap();
    `CHK(irqOut, 1'b0)
    rd(ADDR_EVENT_STATUS, 8'h00);
    nap();
    end_of_test();
  end
endmodule
`default_nettype wire

// ### tb/request_sources.sv
// Purpose: far-side model of the group-two request sources and port C pins
// Assumes: bench commands arrive just after a rising edge
// Notes: requests are one-cycle pulses, pins follow pinDrive one cycle later
`timescale 1ns/1ns
`default_nettype none
module request_sources (
  // clock
  input wire logic mclk,
  // commands from the bench
  input wire logic [3:0] fire,
  input wire logic [irq_group2_pkg::PORT_PINS-1:0] pinDrive,
  // source outputs
  output logic timerThreeRequest,
  output logic serialRxRequest,
  output logic serialTxRequest,
  output logic transferRequest,
  output logic [irq_group2_pkg::PORT_PINS-1:0] portCPins
);
  import irq_group2_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // fire[3] is the timer, down to fire[0] for the transfer engine
  always_ff @(posedge mclk) begin
    {timerThreeRequest, serialRxRequest, serialTxRequest, transferRequest} <= fire;
    portCPins <= pinDrive;
  end
endmodule
`default_nettype wire
